// *** rtl/tmc_store.sv ***
`timescale 1ns/10ps
module tmc_store (
    input  wire logic                       sys_clk_i,
    input  wire logic                       srst_i,
    // Message events from the protocol engine
    input  wire logic                       msg_start_i,
    input  wire logic                       msg_done_i,
    input  wire logic [tmc_pkg::MODE_W-1:0] mode_code_i,
    input  wire logic [tmc_pkg::ADDR_W-1:0] data_ptr_i,
    input  wire logic [tmc_pkg::WORD_W-1:0] time_tag_i,
    input  wire logic                       gap_mode_i,
    input  wire logic                       gap_err_i,
    input  wire logic                       broadcast_i,
    input  wire logic                       wct_err_i,
    input  wire logic                       msg_err_i,
    input  wire logic                       global_busy_i,
    input  wire logic                       per_command_busy,
    input  wire logic                       illegal_i,
    input  wire logic                       undefined_modecode_invalidate,
    input  wire logic                       bus_b_i,
    // Mode data word: host table entry, or internally generated word
    input  wire logic [tmc_pkg::WORD_W-1:0] table_data_i,
    input  wire logic [tmc_pkg::WORD_W-1:0] last_cmd_word_i,
    input  wire logic [tmc_pkg::WORD_W-1:0] selftest_word_i,
    // Transmit side
    output logic                            tx_data_en_o,
    output logic      [tmc_pkg::WORD_W-1:0] tx_data_o,
    output logic                            respond_o,
    // Shared RAM write port
    output logic                            ram_we_o,
    output logic      [tmc_pkg::ADDR_W-1:0] ram_addr_o,
    output logic      [tmc_pkg::WORD_W-1:0] ram_wdata_o,
    output logic      [tmc_pkg::WORD_W-1:0] transmit_mode_message_info,
    output logic                            busy_o
);
    import tmc_pkg::*;

    tmc_state_e             state;
    tmc_state_e             next_state;
    logic [ADDR_W-1:0]      base;
    logic [ADDR_W-1:0]      next_base;
    logic [WORD_W-1:0]      tag;
    logic [WORD_W-1:0]      next_tag;
    logic [WORD_W-1:0]      mdata;
    logic [WORD_W-1:0]      next_mdata;
    logic [MODE_W-1:0]      code;
    logic [MODE_W-1:0]      next_code;
    logic                   with_data;
    logic                   next_with_data;
    logic [WORD_W-1:0]      info;
    logic [WORD_W-1:0]      next_info;
    logic                   next_we;
    logic [ADDR_W-1:0]      next_addr;
    logic [WORD_W-1:0]      next_wdata;
    logic                   next_tx_en;
    logic [WORD_W-1:0]      next_tx_data;
    logic [WORD_W-1:0]      built_info;
    logic                   busy_now;
    logic                   undef_code;
    logic                   in_form;
    logic [WORD_W-1:0]      sel_data;

    assign busy_now   = global_busy_i | per_command_busy;
    assign undef_code = (mode_code_i == UNDEF_CODE_A) || (mode_code_i == UNDEF_CODE_B)
                        || (mode_code_i == UNDEF_CODE_C);
    assign in_form    = !illegal_i && !(undef_code && undefined_modecode_invalidate);
    assign respond_o  = msg_start_i && in_form;
    assign busy_o     = (state != TMC_IDLE);

    tmc_info_build tmc_info_build_i (
        .gap_mode_i  (gap_mode_i),
        .gap_err_i   (gap_err_i),
        .broadcast_i (broadcast_i),
        .wct_err_i   (wct_err_i),
        .msg_err_i   (msg_err_i),
        .busy_i      (busy_now),
        .illegal_i   (illegal_i),
        .bus_b_i     (bus_b_i),
        .mode_code_i (code),
        .info_o      (built_info)
    );

    always_comb begin
        case (mode_code_i)
            TX_LAST_CMD: sel_data = last_cmd_word_i;
            TX_SELFTEST: sel_data = selftest_word_i;
            default:     sel_data = table_data_i;
        endcase
    end

    always_comb begin
        next_state     = state;
        next_base      = base;
        next_tag       = tag;
        next_mdata     = mdata;
        next_code      = code;
        next_with_data = with_data;
        next_info      = info;
        next_we        = 1'b0;
        next_addr      = ram_addr_o;
        next_wdata     = ram_wdata_o;
        next_tx_en     = 1'b0;
        next_tx_data   = tx_data_o;
        case (state)
            TMC_IDLE: begin
                if (msg_start_i) begin
                    next_code      = mode_code_i;
                    next_base      = data_ptr_i;
                    next_tag       = time_tag_i;
                    next_with_data = (mode_code_i >= DATA_CODE_MIN)
                                     && !busy_now && in_form;
                    next_mdata     = sel_data;
                    if ((mode_code_i >= DATA_CODE_MIN) && !busy_now && in_form) begin
                        next_tx_en   = 1'b1;
                        next_tx_data = sel_data;
                    end
                    next_state = TMC_INFO;
                end
            end
            TMC_INFO: begin
                if (msg_done_i) begin
                    next_info  = built_info;
                    next_we    = 1'b1;
                    next_addr  = base;
                    next_wdata = built_info;
                    next_state = TMC_TAG;
                end
            end
            TMC_TAG: begin
                next_we    = 1'b1;
                next_addr  = base + OFS_TIME_TAG;
                next_wdata = tag;
                next_state = with_data ? TMC_DATA : TMC_IDLE;
            end
            TMC_DATA: begin
                next_we    = 1'b1;
                next_addr  = base + OFS_MODE_DATA;
                next_wdata = mdata;
                next_state = TMC_IDLE;
            end
            default: next_state = TMC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state                      <= TMC_IDLE;
            base                       <= '0;
            tag                        <= '0;
            mdata                      <= '0;
            code                       <= '0;
            with_data                  <= 1'b0;
            info                       <= INFO_RESET;
            ram_we_o                   <= 1'b0;
            ram_addr_o                 <= '0;
            ram_wdata_o                <= '0;
            tx_data_en_o               <= 1'b0;
            tx_data_o                  <= '0;
        end else begin
            state                      <= next_state;
            base                       <= next_base;
            tag                        <= next_tag;
            mdata                      <= next_mdata;
            code                       <= next_code;
            with_data                  <= next_with_data;
            info                       <= next_info;
            ram_we_o                   <= next_we;
            ram_addr_o                 <= next_addr;
            ram_wdata_o                <= next_wdata;
            tx_data_en_o               <= next_tx_en;
            tx_data_o                  <= next_tx_data;
        end
    end

    assign transmit_mode_message_info = info;
endmodule

// *** rtl/tmc_pkg.sv ***
// Function
// - Store info word, time tag, then data
// - Codes 18/19 store generated transmitted word
// - Data pointer addresses the info word
// - Undefined codes answer normally unless illegalized or the invalidate option is set
// - No-data codes store only two words
// - Write results only after message completes
// - Gap mode: bit 13 flags gap error
// - Other mode: bit 13 flags broadcast
// - Bit 12 flags unexpected data words
// - Bit 10 flags message error change
// - Bit 9 flags busy, no data sent
// - Bit 8 flags illegalized command
// - Bit 5 records bus A or B
// - Bits 4..0 hold mode code
package tmc_pkg;
    localparam int          WORD_W          = 16;
    localparam int          ADDR_W          = 15;
    localparam int          MODE_W          = 5;
    localparam int          BIT_GAP_OR_BROADCAST_FLAG   = 13;
    localparam int          BIT_WCT_ERR     = 12;
    localparam int          BIT_MSG_ERR     = 10;
    localparam int          BIT_BUSY        = 9;
    localparam int          BIT_ILLEGAL     = 8;
    localparam int          BIT_BUS_SEL     = 5;
    localparam logic [4:0]  DATA_CODE_MIN   = 5'h10;
    localparam logic [4:0]  TX_VECTOR_CODE  = 5'h10;
    localparam logic [4:0]  TX_LAST_CMD     = 5'h12;
    localparam logic [4:0]  TX_SELFTEST     = 5'h13;
    localparam logic [4:0]  UNDEF_CODE_A    = 5'h11;
    localparam logic [4:0]  UNDEF_CODE_B    = 5'h14;
    localparam logic [4:0]  UNDEF_CODE_C    = 5'h15;
    localparam logic [14:0] OFS_TIME_TAG    = 15'h0001;
    localparam logic [14:0] OFS_MODE_DATA   = 15'h0002;
    localparam logic [15:0] INFO_RESET      = 16'h0000;
    typedef enum logic [1:0] {
        TMC_IDLE,
        TMC_INFO,
        TMC_TAG,
        TMC_DATA
    } tmc_state_e;
endpackage

// *** rtl/tmc_info_build.sv ***
`timescale 1ns/10ps
module tmc_info_build (
    input  wire logic                       gap_mode_i,
    input  wire logic                       gap_err_i,
    input  wire logic                       broadcast_i,
    input  wire logic                       wct_err_i,
    input  wire logic                       msg_err_i,
    input  wire logic                       busy_i,
    input  wire logic                       illegal_i,
    input  wire logic                       bus_b_i,
    input  wire logic [tmc_pkg::MODE_W-1:0] mode_code_i,
    output logic      [tmc_pkg::WORD_W-1:0] info_o
);
    import tmc_pkg::*;

    always_comb begin
        info_o = INFO_RESET;
        info_o[BIT_GAP_OR_BROADCAST_FLAG] = gap_mode_i ? gap_err_i : broadcast_i;
        info_o[BIT_WCT_ERR]   = wct_err_i;
        info_o[BIT_MSG_ERR]   = msg_err_i | gap_err_i | wct_err_i;
        info_o[BIT_BUSY]      = busy_i;
        info_o[BIT_ILLEGAL]   = illegal_i;
        info_o[BIT_BUS_SEL]   = bus_b_i;
        info_o[MODE_W-1:0]    = mode_code_i;
    end
endmodule

// *** tb/tmc_store_properties.sv ***
`timescale 1ns/10ps
module tmc_store_checker (
    input wire logic        sys_clk_i,
    input wire logic        srst_i,
    input wire logic        msg_start_i,
    input wire logic        msg_done_i,
    input wire logic [4:0]  mode_code_i,
    input wire logic [14:0] data_ptr_i,
    input wire logic        global_busy_i,
    input wire logic        per_command_busy,
    input wire logic        illegal_i,
    input wire logic        undefined_modecode_invalidate,
    input wire logic        tx_data_en_o,
    input wire logic        ram_we_o,
    input wire logic [14:0] ram_addr_o,
    input wire logic [15:0] ram_wdata_o,
    input wire logic        busy_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    logic [14:0] base;
    logic [4:0]  code;
    logic        nok;
    logic        undef_drop;
    // Undefined data codes are refused when the invalidate option is set
    assign undef_drop = undefined_modecode_invalidate
                        && (mode_code_i == 5'h11 || mode_code_i == 5'h14 || mode_code_i == 5'h15);
    always_ff @(posedge sys_clk_i) begin
        if (msg_start_i && !busy_o) begin
            base <= data_ptr_i;
            code <= mode_code_i;
            nok  <= global_busy_i || per_command_busy || illegal_i || undef_drop;
        end
    end
    info_addr_a: assert property (msg_done_i && busy_o |=> ram_we_o && ram_addr_o == base)
        else $error("info word not at buffer start");
    tag_addr_a: assert property (msg_done_i && busy_o |=> ##1 ram_we_o && ram_addr_o == base + 15'h0001)
        else $error("time tag word misplaced");
    data_third_a: assert property (msg_done_i && busy_o && code >= 5'h10 && !nok |=> ##2 ram_we_o && ram_addr_o == base + 15'h0002)
        else $error("mode data word misplaced");
    nodata_two_a: assert property (msg_done_i && busy_o && code < 5'h10 |=> ##2 !ram_we_o && !busy_o)
        else $error("extra word stored");
    mode_field_a: assert property (msg_done_i && busy_o |=> ram_wdata_o[4:0] == code)
        else $error("mode code field wrong");
    unused_zero_a: assert property (msg_done_i && busy_o |=> (ram_wdata_o & 16'hC8C0) == 16'h0000)
        else $error("unused info bits set");
    write_after_done_a: assert property ($rose(ram_we_o) |-> $past(msg_done_i))
        else $error("write before completion");
    tx_after_start_a: assert property (msg_start_i && !busy_o && mode_code_i >= 5'h10 && !global_busy_i && !per_command_busy && !illegal_i && !undef_drop |=> tx_data_en_o)
        else $error("data word not sent");
    busy_no_tx_a: assert property (msg_start_i && !busy_o && (global_busy_i || per_command_busy) |=> !tx_data_en_o)
        else $error("data sent while busy");
    cover property (msg_done_i && busy_o && code >= 5'h10 && !nok);
    cover property (msg_start_i && !busy_o && global_busy_i);
    cover property (msg_start_i && !busy_o && illegal_i);
    cover property (msg_start_i && !busy_o && undef_drop);
endmodule
bind tmc_store tmc_store_checker tmc_store_checker_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .msg_start_i(msg_start_i), .msg_done_i(msg_done_i), .mode_code_i(mode_code_i),
    .data_ptr_i(data_ptr_i), .global_busy_i(global_busy_i), .per_command_busy(per_command_busy),
    .illegal_i(illegal_i), .undefined_modecode_invalidate(undefined_modecode_invalidate),
    .tx_data_en_o(tx_data_en_o), .ram_we_o(ram_we_o),
    .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o), .busy_o(busy_o));

// *** tb/tmc_host_table.sv ***
`timescale 1ns/10ps
module tmc_host_table (
    input  wire logic [4:0]  mode_code_i,
    output logic      [15:0] table_data_o
);
    logic [15:0] tbl_mem [32];
    // Host fills every entry before the first command can arrive
    initial begin
        for (int k = 0; k < 32; k++) begin
            tbl_mem[k] = {8'hA5, 3'h0, 5'(k)};
        end
    end
    assign table_data_o = tbl_mem[mode_code_i];
endmodule

// *** tb/tmc_store_bench.sv ***
`timescale 1ns/10ps
module tmc_store_bench;
    import tmc_pkg::*;
    logic clk = 1'b0, srst = 1'b1, start = 1'b0, done = 1'b0, gmode = 1'b0, gerr = 1'b0;
    logic bcast = 1'b0, wct = 1'b0, message_error_flag = 1'b0, gbusy = 1'b0, cbusy = 1'b0, ill = 1'b0;
    logic busb = 1'b0, inv = 1'b0, txen, resp, we, bsy;
    logic [4:0]  code = 5'h00;
    logic [14:0] ptr = 15'h0000, addr;
    logic [15:0] tag = 16'h0000, tdata, info, txd, wdata;
    logic [4:0]  codes [11] = '{5'h00, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15,
                                5'h1F, 5'h11, 5'h10};
    logic [14:0] qa [$];
    logic [15:0] qd [$];
    int error_cnt = 0;
    int checked = 0;
    tmc_host_table tmc_host_table_i (.mode_code_i(code), .table_data_o(tdata));
    tmc_store tmc_store_i (.sys_clk_i(clk), .srst_i(srst), .msg_start_i(start), .msg_done_i(done),
        .mode_code_i(code), .data_ptr_i(ptr), .time_tag_i(tag), .gap_mode_i(gmode),
        .gap_err_i(gerr), .broadcast_i(bcast), .wct_err_i(wct), .msg_err_i(message_error_flag),
        .global_busy_i(gbusy), .per_command_busy(cbusy), .illegal_i(ill),
        .undefined_modecode_invalidate(inv), .bus_b_i(busb), .table_data_i(tdata),
        .last_cmd_word_i(16'h1234), .selftest_word_i(16'h4321), .tx_data_en_o(txen),
        .tx_data_o(txd), .respond_o(resp), .ram_we_o(we), .ram_addr_o(addr),
        .ram_wdata_o(wdata), .transmit_mode_message_info(info), .busy_o(bsy));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(negedge clk) begin
        if (we === 1'b1) begin
            qa.push_back(addr);
            qd.push_back(wdata);
        end
    end
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic msg(input int i, input logic [4:0] c);
        logic [7:0]  f;
        logic [15:0] ei, ed;
        logic        dat;
        logic        drop;
        f = 8'(i * 19);
        @(negedge clk);
        {busb, message_error_flag, wct, bcast, gerr, gmode} = f[5:0];
        gbusy = (i == 7);
        cbusy = (i == 2);
        ill = (i == 8);
        // Last two commands run with the undefined-code invalidate option set
        inv = (i >= 9);
        ptr = 15'h0500 + 15'(i * 4);
        tag = 16'h0100 + 16'(i);
        code = c;
        start = 1'b1;
        ed = (c == TX_LAST_CMD) ? 16'h1234 : (c == TX_SELFTEST) ? 16'h4321 : {8'hA5, 3'h0, c};
        drop = inv && (c == UNDEF_CODE_A || c == UNDEF_CODE_B || c == UNDEF_CODE_C);
        dat = c >= DATA_CODE_MIN && !gbusy && !cbusy && !ill && !drop;
        ei = {2'b00, gmode ? gerr : bcast, wct, 1'b0, message_error_flag | gerr | wct, gbusy | cbusy, ill,
              2'b00, busb, c};
        #1 check("respond", 16'(!ill && !drop), 16'(resp));
        qa.delete();
        qd.delete();
        @(negedge clk);
        start = 1'b0;
        tag = 16'hFFFF;
        check("tx_en", 16'(dat), 16'(txen));
        if (dat) check("tx_data", ed, txd);
        repeat (2) @(negedge clk);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        repeat (4) @(negedge clk);
        check("writes", dat ? 16'h0003 : 16'h0002, 16'(qa.size()));
        foreach (qa[k]) check("addr", 16'(ptr) + 16'(k), 16'(qa[k]));
        check("info", ei, qd[0]);
        check("time_tag", 16'h0100 + 16'(i), qd[1]);
        if (dat) check("mode_data", ed, qd[2]);
        check("info_reg", ei, info);
        check("idle", 16'h0000, 16'(bsy));
    endtask
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        check("info_rst", INFO_RESET, info);
        foreach (codes[i]) msg(i, codes[i]);
        finish_test;
    end
    initial begin
        #(3000 * 100);
        error_cnt++;
        finish_test;
    end
endmodule
